// ### hdl/ims_cfg.svh
// Overview of operation
// - route inputs slot by slot per selects
// - eleven single-ended or seven paired inputs
// - slots per frame equal slot count field, capped at eleven
// - frames start at slot 0, stop at count
// - handles 0-A: pairs 0,2,4,6; voltages 8-A
// - selects packed two per byte, descending
// - remote pair ignores its differential bit
// - four bits pair current pins differentially
// - preamp bit selects gain eight or one
// - slot states begin on slow clock rise
// - slot and frame lengths follow formulas
// - remote samples taken in frame second half
`ifndef IMS_CFG_SVH
`define IMS_CFG_SVH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define IMS_OFS_COUNT_SLOT10 16'h2100
`define IMS_OFS_SLOT8_9 16'h2101
`define IMS_OFS_SLOT6_7 16'h2102
`define IMS_OFS_SLOT4_5 16'h2103
`define IMS_OFS_SLOT2_3 16'h2104
`define IMS_OFS_SLOT0_1 16'h2105
`define IMS_OFS_EQUATION 16'h2106
`define IMS_OFS_FILTER_PAIR 16'h210c
`define IMS_OFS_RATE_PLL 16'h2200
`define IMS_OFS_PREAMP 16'h2704
`define IMS_OFS_REMOTE 16'h2709

// ----------------------------------------
// register indices and fields
// ----------------------------------------
`define IMS_IDX_COUNT 4'h0
`define IMS_IDX_SLOT0_1 4'h5
`define IMS_IDX_EQUATION 4'h6
`define IMS_IDX_FILTER_PAIR 4'h7
`define IMS_IDX_RATE_PLL 4'h8
`define IMS_IDX_PREAMP 4'h9
`define IMS_IDX_REMOTE 4'ha
`define IMS_IDX_NONE 4'hf
`define IMS_NUM_REGS 11
`define IMS_RESET_VALUE 8'h00
`define IMS_UNMAPPED_READ 8'h00
`define IMS_COUNT_MSB 7
`define IMS_COUNT_LSB 4
`define IMS_FIR_MSB 2
`define IMS_FIR_LSB 1
`define IMS_DIFF_MSB 7
`define IMS_DIFF_LSB 4
`define IMS_ADC_DIV_BIT 5
`define IMS_PLL_FAST_BIT 4
`define IMS_PREAMP_BIT 5
`define IMS_REMOTE_MSB 5
`define IMS_REMOTE_LSB 3
`define IMS_EQU_MSB 7
`define IMS_EQU_LSB 5

// ----------------------------------------
// slots and timing counts
// ----------------------------------------
`define IMS_MAX_SLOTS 4'hb
`define IMS_FIRST_VOLTAGE 4'h8
`define IMS_SLOW_PLL_MULT 8'h03
`define IMS_TAIL_FAST 8'h01
`define IMS_TAIL_SLOW 8'h03

`endif

// ### hdl/ims_input_mux_sequencer.sv
`timescale 1ns/100ps
`default_nettype none
`include "ims_cfg.svh"

module ims_input_mux_sequencer (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic slow_32k_clock,
  input wire logic [15:0] io_addr,
  input wire logic io_wr_en,
  input wire logic io_rd_en,
  input wire logic [7:0] io_wdata,
  output logic [7:0] io_rdata,
  output logic [3:0] mux_select,
  output logic [3:0] slot_index,
  output logic slot_active,
  output logic slot_start,
  output logic frame_start,
  output logic remote_sample_window,
  output logic input_is_voltage,
  output logic [3:0] differential_pair_enable,
  output logic preamp_gain8,
  output logic [2:0] remote_sensor_enable,
  output logic [1:0] filter_length,
  output logic rate_divide,
  output logic pll_fast,
  output logic [2:0] energy_equation_select
);

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [7:0] regs_ff [0:`IMS_NUM_REGS-1];
  logic [7:0] rdata_ff;

  function automatic logic [3:0] reg_index(input logic [15:0] a);
    case (a)
      `IMS_OFS_COUNT_SLOT10: reg_index = 4'h0;
      `IMS_OFS_SLOT8_9: reg_index = 4'h1;
      `IMS_OFS_SLOT6_7: reg_index = 4'h2;
      `IMS_OFS_SLOT4_5: reg_index = 4'h3;
      `IMS_OFS_SLOT2_3: reg_index = 4'h4;
      `IMS_OFS_SLOT0_1: reg_index = 4'h5;
      `IMS_OFS_EQUATION: reg_index = `IMS_IDX_EQUATION;
      `IMS_OFS_FILTER_PAIR: reg_index = `IMS_IDX_FILTER_PAIR;
      `IMS_OFS_RATE_PLL: reg_index = `IMS_IDX_RATE_PLL;
      `IMS_OFS_PREAMP: reg_index = `IMS_IDX_PREAMP;
      `IMS_OFS_REMOTE: reg_index = `IMS_IDX_REMOTE;
      default: reg_index = `IMS_IDX_NONE;
    endcase
  endfunction

  function automatic logic [3:0] pair_index(input logic [3:0] idx);
    return 4'(`IMS_IDX_SLOT0_1 - {1'b0, idx[3:1]});
  endfunction

  // odd slots in the upper nibble
  function automatic logic [3:0] slot_handle(input logic [7:0] pair, input logic odd);
    return odd ? pair[7:4] : pair[3:0];
  endfunction

  wire [3:0] acc_idx = reg_index(io_addr);
  wire acc_hit = (acc_idx != `IMS_IDX_NONE);
  wire [7:0] rd_value = acc_hit ? regs_ff[acc_idx] : `IMS_UNMAPPED_READ;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < `IMS_NUM_REGS; i++) begin
        regs_ff[i] <= `IMS_RESET_VALUE;
      end
      rdata_ff <= `IMS_UNMAPPED_READ;
    end else begin
      if (io_wr_en && acc_hit) begin
        regs_ff[acc_idx] <= io_wdata;
      end
      if (io_rd_en) begin
        rdata_ff <= rd_value;
      end
    end
  end

  // ----------------------------------------
  // field views
  // ----------------------------------------
  wire [3:0] count_fld = regs_ff[`IMS_IDX_COUNT][`IMS_COUNT_MSB:`IMS_COUNT_LSB];
  wire [7:0] filt_reg = regs_ff[`IMS_IDX_FILTER_PAIR];
  wire [7:0] rate_reg = regs_ff[`IMS_IDX_RATE_PLL];
  wire [1:0] fir_fld = filt_reg[`IMS_FIR_MSB:`IMS_FIR_LSB];
  wire [3:0] diff_fld = filt_reg[`IMS_DIFF_MSB:`IMS_DIFF_LSB];
  wire [2:0] rmt_fld = regs_ff[`IMS_IDX_REMOTE][`IMS_REMOTE_MSB:`IMS_REMOTE_LSB];
  wire preamp_bit = regs_ff[`IMS_IDX_PREAMP][`IMS_PREAMP_BIT];
  wire div_bit = rate_reg[`IMS_ADC_DIV_BIT];
  wire fast_bit = rate_reg[`IMS_PLL_FAST_BIT];
  // slots per frame, capped at eleven
  wire [3:0] cnt_eff = (count_fld > `IMS_MAX_SLOTS) ? `IMS_MAX_SLOTS : count_fld;
  wire [7:0] slot_len = ims_pkg::ims_slot_length(fir_fld, div_bit, fast_bit);
  wire [7:0] tail_len = fast_bit ? `IMS_TAIL_FAST : `IMS_TAIL_SLOW;
  wire [8:0] frame_len = 9'({1'b0, slot_len} * {5'h00, cnt_eff}) + {1'b0, tail_len};

  // ----------------------------------------
  // frame sequencer
  // ----------------------------------------
  ims_pkg::ims_state_t state_ff, nxt_state;
  logic slow_prev_ff;
  logic [3:0] slot_idx_ff, nxt_idx;
  logic [3:0] cnt_lat_ff;
  logic [7:0] slot_len_lat_ff, tail_lat_ff;
  logic [8:0] frame_len_lat_ff, frame_tick_ff;
  logic start_frame;
  logic seg_last;

  // slot boundaries on slow clock rise
  wire tick = slow_32k_clock && !slow_prev_ff;
  wire in_slot = (state_ff == ims_pkg::IMS_SLOT);
  wire last_slot = (slot_idx_ff == 4'(cnt_lat_ff - 4'h1));
  wire [7:0] seg_len = in_slot ? slot_len_lat_ff : tail_lat_ff;
  wire seg_clear = (state_ff == ims_pkg::IMS_IDLE);

  ims_segment_timer #(.LEN_W(8)) u_seg (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .tick(tick),
    .clear(seg_clear),
    .seg_len(seg_len),
    .seg_last(seg_last)
  );

  always_comb begin
    nxt_state = state_ff;
    nxt_idx = slot_idx_ff;
    start_frame = 1'b0;
    case (state_ff)
      ims_pkg::IMS_IDLE: begin
        if (tick && cnt_eff != 4'h0) begin
          start_frame = 1'b1;
        end
      end
      ims_pkg::IMS_SLOT: begin
        if (seg_last) begin
          if (last_slot) begin
            nxt_state = ims_pkg::IMS_TAIL;
          end else begin
            nxt_idx = 4'(slot_idx_ff + 4'h1);
          end
        end
      end
      ims_pkg::IMS_TAIL: begin
        if (seg_last) begin
          if (cnt_eff != 4'h0) begin
            start_frame = 1'b1;
          end else begin
            nxt_state = ims_pkg::IMS_IDLE;
          end
        end
      end
      default: begin
        nxt_state = ims_pkg::IMS_IDLE;
      end
    endcase
    if (start_frame) begin
      nxt_state = ims_pkg::IMS_SLOT;
      nxt_idx = 4'h0;
    end
  end

  wire [8:0] nxt_frame_len = start_frame ? frame_len : frame_len_lat_ff;
  wire [8:0] nxt_frame_tick = start_frame ? 9'h000 :
    ((tick && !seg_clear) ? 9'(frame_tick_ff + 9'h001) : frame_tick_ff);
  wire nxt_window = (nxt_state != ims_pkg::IMS_IDLE) &&
    ({nxt_frame_tick, 1'b0} >= {1'b0, nxt_frame_len});
  // handle routed for the coming slot
  wire [7:0] nxt_pair = regs_ff[pair_index(nxt_idx)];
  wire [3:0] nxt_handle = slot_handle(nxt_pair, nxt_idx[0]);
  wire nxt_slot_start = start_frame || (in_slot && seg_last && !last_slot);

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= ims_pkg::IMS_IDLE;
      slow_prev_ff <= 1'b0;
      slot_idx_ff <= 4'h0;
      cnt_lat_ff <= 4'h0;
      slot_len_lat_ff <= 8'h00;
      tail_lat_ff <= 8'h00;
      frame_len_lat_ff <= 9'h000;
      frame_tick_ff <= 9'h000;
    end else begin
      state_ff <= nxt_state;
      slow_prev_ff <= slow_32k_clock;
      slot_idx_ff <= nxt_idx;
      frame_tick_ff <= nxt_frame_tick;
      if (start_frame) begin
        cnt_lat_ff <= cnt_eff;
        slot_len_lat_ff <= slot_len;
        tail_lat_ff <= tail_len;
        frame_len_lat_ff <= frame_len;
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  logic [3:0] mux_sel_ff, slot_index_ff, diff_eff_ff;
  logic slot_active_ff, slot_start_ff, frame_start_ff, window_ff, voltage_ff, gain8_ff;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      mux_sel_ff <= 4'h0;
      slot_index_ff <= 4'h0;
      slot_active_ff <= 1'b0;
      slot_start_ff <= 1'b0;
      frame_start_ff <= 1'b0;
      window_ff <= 1'b0;
      voltage_ff <= 1'b0;
      diff_eff_ff <= 4'h0;
      gain8_ff <= 1'b0;
    end else begin
      mux_sel_ff <= nxt_handle;
      slot_index_ff <= nxt_idx;
      slot_active_ff <= (nxt_state == ims_pkg::IMS_SLOT);
      slot_start_ff <= nxt_slot_start;
      frame_start_ff <= start_frame;
      window_ff <= nxt_window;
      // handles 8 to A are voltages
      voltage_ff <= (nxt_handle >= `IMS_FIRST_VOLTAGE);
      diff_eff_ff <= {diff_fld[3:1] & ~rmt_fld, diff_fld[0]};
      gain8_ff <= preamp_bit;
    end
  end

  assign io_rdata = rdata_ff;
  assign mux_select = mux_sel_ff;
  assign slot_index = slot_index_ff;
  assign slot_active = slot_active_ff;
  assign slot_start = slot_start_ff;
  assign frame_start = frame_start_ff;
  assign remote_sample_window = window_ff;
  assign input_is_voltage = voltage_ff;
  assign differential_pair_enable = diff_eff_ff;
  assign preamp_gain8 = gain8_ff;
  assign remote_sensor_enable = rmt_fld;
  assign filter_length = fir_fld;
  assign rate_divide = div_bit;
  assign pll_fast = fast_bit;
  assign energy_equation_select = regs_ff[`IMS_IDX_EQUATION][`IMS_EQU_MSB:`IMS_EQU_LSB];

  // ----------------------------------------
  // checks
  // ----------------------------------------
  wire [7:0] cur_pair = regs_ff[pair_index(slot_index_ff)];

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  AST_IDLE_ON_ZERO: assert property (
    (state_ff == ims_pkg::IMS_IDLE && cnt_eff == 4'h0) |=> !frame_start_ff && !slot_active_ff)
    else $error("sequencer left idle with zero count");
  AST_FRAME_AT_SLOT0: assert property (
    frame_start_ff |-> slot_index_ff == 4'h0 && slot_active_ff && slot_start_ff)
    else $error("frame did not open at slot 0");
  AST_SLOT_ON_RISE: assert property (
    slot_start_ff |-> $past(slow_32k_clock) && !$past(slow_prev_ff))
    else $error("slot began without slow clock rise");
  AST_SLOT_BELOW_COUNT: assert property (
    slot_active_ff |-> slot_index_ff < cnt_lat_ff && slot_index_ff < `IMS_MAX_SLOTS)
    else $error("slot index beyond programmed count");
  AST_MUX_FOLLOWS_FIELD: assert property (
    (slot_active_ff && !$past(io_wr_en)) |->
      mux_select == slot_handle(cur_pair, slot_index_ff[0]))
    else $error("routed handle differs from slot field");
  AST_REMOTE_NO_DIFF: assert property (
    (rmt_fld == 3'h7) |=> differential_pair_enable[3:1] == 3'h0)
    else $error("remote pair kept differential mode");
  AST_DIFF_PAIR0: assert property (
    diff_fld[0] ##1 diff_fld[0] |-> differential_pair_enable[0])
    else $error("pair 0 not differential");
  AST_PREAMP_GAIN: assert property (
    $changed(preamp_bit) |=> (preamp_gain8 == $past(preamp_bit)))
    else $error("preamp gain did not follow control bit");
  AST_WINDOW_SECOND_HALF: assert property (
    frame_start_ff |-> !remote_sample_window)
    else $error("remote window open at frame start");
  AST_FRAME_LENGTH: assert property (
    (state_ff == ims_pkg::IMS_TAIL && seg_last) |->
      frame_tick_ff == 9'(frame_len_lat_ff - 9'h001))
    else $error("frame length differs from formula");
  AST_VOLTAGE_HANDLE: assert property (
    slot_active_ff |-> input_is_voltage == (mux_select >= `IMS_FIRST_VOLTAGE))
    else $error("voltage flag disagrees with handle");

  COV_FRAME_START: cover property (frame_start_ff);
  COV_BACK_TO_BACK: cover property (state_ff == ims_pkg::IMS_TAIL && seg_last && start_frame);
  COV_WINDOW: cover property ($rose(remote_sample_window));
  COV_TO_IDLE: cover property (state_ff == ims_pkg::IMS_TAIL ##1 state_ff == ims_pkg::IMS_IDLE);

endmodule

`default_nettype wire

// ### hdl/ims_pkg.sv
`include "ims_cfg.svh"

package ims_pkg;

  typedef enum logic [2:0] {
    IMS_IDLE = 3'b001,
    IMS_SLOT = 3'b010,
    IMS_TAIL = 3'b100
  } ims_state_t;

  // slow clock cycles per slot
  function automatic logic [7:0] ims_slot_length(input logic [1:0] fir, input logic div,
                                                 input logic fast);
    logic [7:0] base;
    base = 8'({6'h00, fir} + 8'h01) * (div ? 8'h02 : 8'h01);
    return fast ? base : 8'(base * `IMS_SLOW_PLL_MULT);
  endfunction

endpackage

// ### hdl/ims_segment_timer.sv
`timescale 1ns/100ps
`default_nettype none

module ims_segment_timer #(
  parameter int LEN_W = 8
) (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [LEN_W-1:0] seg_len,
  output logic seg_last
);

  logic [LEN_W-1:0] cnt_ff;
  logic [LEN_W-1:0] nxt_cnt;

  // ----------------------------------------
  // tick counting within one segment
  // ----------------------------------------
  assign seg_last = tick && (cnt_ff >= LEN_W'(seg_len - LEN_W'(1)));
  assign nxt_cnt = clear ? '0 : (seg_last ? '0 : (tick ? LEN_W'(cnt_ff + LEN_W'(1)) : cnt_ff));

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

`default_nettype wire

// ### verification/ims_far_side.sv
`timescale 1ns/100ps
`default_nettype none

module ims_far_side #(
  parameter int HALF = 20
) (
  input wire logic slot_start,
  input wire logic [3:0] mux_select,
  output logic slow_32k_clock,
  output logic [3:0] last_handle
);
  // ----------------------------------------
  // slow clock source
  // ----------------------------------------
  // free running, offset so no edge meets a core edge
  initial begin
    slow_32k_clock = 1'b0;
    #13;
    forever #(HALF * 50) slow_32k_clock = ~slow_32k_clock;
  end

  // ----------------------------------------
  // converter input
  // ----------------------------------------
  initial last_handle = 4'h0;
  // sample once the launching edge has settled
  always @(posedge slot_start) begin
    #1;
    last_handle = mux_select;
  end
endmodule

`default_nettype wire

// ### verification/tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ims_cfg.svh"

module tb;
  logic core_clk, reset_n, slow_32k_clock, io_wr_en, io_rd_en, rd_d, fresh, rmt_on, win_d;
  logic [15:0] io_addr;
  logic [7:0] io_wdata, io_rdata, exp_e, d;
  logic [3:0] mux_select, slot_index, differential_pair_enable, conv_handle;
  logic slot_active, slot_start, frame_start, remote_sample_window, input_is_voltage;
  logic preamp_gain8, rate_divide, pll_fast;
  logic [2:0] remote_sensor_enable, energy_equation_select;
  logic [1:0] filter_length;
  logic [31:0] seed;
  int err_count, samples_checked, cycles, gap, exp_frame;
  logic [7:0] rd_q[$];
  logic [7:0] slot_q[$];
  logic [15:0] ofs[11] = '{`IMS_OFS_COUNT_SLOT10, `IMS_OFS_SLOT8_9, `IMS_OFS_SLOT6_7,
    `IMS_OFS_SLOT4_5, `IMS_OFS_SLOT2_3, `IMS_OFS_SLOT0_1, `IMS_OFS_EQUATION,
    `IMS_OFS_FILTER_PAIR, `IMS_OFS_RATE_PLL, `IMS_OFS_PREAMP, `IMS_OFS_REMOTE};

  ims_input_mux_sequencer u_dut (.core_clk(core_clk), .reset_n(reset_n),
    .slow_32k_clock(slow_32k_clock), .io_addr(io_addr), .io_wr_en(io_wr_en),
    .io_rd_en(io_rd_en), .io_wdata(io_wdata), .io_rdata(io_rdata), .mux_select(mux_select),
    .slot_index(slot_index), .slot_active(slot_active), .slot_start(slot_start),
    .frame_start(frame_start), .remote_sample_window(remote_sample_window),
    .input_is_voltage(input_is_voltage), .differential_pair_enable(differential_pair_enable),
    .preamp_gain8(preamp_gain8), .remote_sensor_enable(remote_sensor_enable),
    .filter_length(filter_length), .rate_divide(rate_divide), .pll_fast(pll_fast),
    .energy_equation_select(energy_equation_select));

  ims_far_side #(.HALF(20)) u_far (.slot_start(slot_start), .mux_select(mux_select),
    .slow_32k_clock(slow_32k_clock), .last_handle(conv_handle));

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check_val(input string name, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic io_write(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #2;
    io_addr = a;
    io_wdata = v;
    io_wr_en = 1'b1;
    @(posedge core_clk);
    #2;
    io_wr_en = 1'b0;
  endtask

  task automatic io_read(input logic [15:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #2;
    io_addr = a;
    io_rd_en = 1'b1;
    rd_q.push_back(v);
    @(posedge core_clk);
    #2;
    io_rd_en = 1'b0;
  endtask

  task automatic run_frames(input logic [1:0] fir, input logic div, input logic fast,
                            input logic [3:0] cnt);
    int n_slots;
    int len;
    logic [3:0] base;
    logic [3:0] sel[11];
    n_slots = (cnt > 4'hb) ? 11 : int'(cnt);
    len = (int'(fir) + 1) * (int'(div) + 1) * (fast ? 1 : 3);
    seed = lfsr_next(seed);
    base = 4'(seed[15:0] % 11);
    if (rmt_on) base = 4'((22 - n_slots) % 11);
    io_write(`IMS_OFS_COUNT_SLOT10, 8'h00);
    io_write(`IMS_OFS_FILTER_PAIR, {5'h00, fir, 1'b0});
    io_write(`IMS_OFS_RATE_PLL, {2'h0, div, fast, 4'h0});
    for (int n = 0; n < 11; n++) sel[n] = 4'((int'(base) + n) % 11);
    for (int b = 0; b < 5; b++) io_write(16'h2105 - 16'(b), {sel[2 * b + 1], sel[2 * b]});
    exp_frame = (fast ? 1 : 3) + len * n_slots;
    fresh = 1'b1;
    for (int f = 0; f < 2; f++)
      for (int n = 0; n < n_slots; n++) slot_q.push_back({4'(n), sel[n]});
    io_write(`IMS_OFS_COUNT_SLOT10, {cnt, sel[10]});
    for (int i = 0; i < 8000 && slot_q.size() != 0; i++) @(posedge core_clk);
    if (slot_q.size() != 0) begin
      err_count++;
      $display("BAD slot_queue expected 0 seen %0d", slot_q.size());
      slot_q.delete();
    end
    io_write(`IMS_OFS_COUNT_SLOT10, {4'h0, sel[10]});
    repeat (exp_frame * 40 + 40) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // output watcher
  // ----------------------------------------
  always @(posedge core_clk) begin
    rd_d <= io_rd_en;
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      test_done();
    end
  end

  always @(negedge core_clk) begin
    gap = gap + 1;
    if (rd_d === 1'b1) begin
      check_val("io_rdata", 16'(rd_q.pop_front()), {8'h00, io_rdata});
    end
    if (remote_sample_window === 1'b1 && win_d !== 1'b1) begin
      check_val("window_rise", 16'(((exp_frame + 1) / 2) * 40), 16'(gap));
    end
    win_d = remote_sample_window;
    if (slot_start === 1'b1) begin
      exp_e = (slot_q.size() != 0) ? slot_q.pop_front() : 8'hff;
      check_val("slot_index", 16'(exp_e[7:4]), 16'(slot_index));
      check_val("mux_select", 16'(exp_e[3:0]), 16'(mux_select));
      check_val("conv_handle", 16'(exp_e[3:0]), 16'(conv_handle));
      check_val("input_is_voltage", 16'(exp_e[3:0] >= 4'h8), 16'(input_is_voltage));
      check_val("slot_active", 16'h0001, 16'(slot_active));
    end
    if (frame_start === 1'b1) begin
      check_val("frame_index", 16'h0000, 16'(slot_index));
      check_val("remote_window", 16'h0000, 16'(remote_sample_window));
      if (!fresh) check_val("frame_cycles", 16'(exp_frame * 40), 16'(gap));
      fresh = 1'b0;
      gap = 0;
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    io_addr = 16'h0000;
    io_wdata = 8'h00;
    io_wr_en = 1'b0;
    io_rd_en = 1'b0;
    reset_n = 1'b0;
    seed = 32'h9e4d;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    gap = 0;
    exp_frame = 0;
    fresh = 1'b1;
    rmt_on = 1'b0;
    repeat (6) @(posedge core_clk);
    #2;
    reset_n = 1'b1;
    foreach (ofs[i]) io_read(ofs[i], 8'h00);
    foreach (ofs[i]) begin
      seed = lfsr_next(seed);
      d = seed[7:0] & ((i == 0) ? 8'h0f : 8'hff);
      io_write(ofs[i], d);
      io_read(ofs[i], d);
    end
    io_write(16'h2107, 8'h5a);
    io_read(16'h2107, 8'h00);
    io_write(`IMS_OFS_FILTER_PAIR, 8'hf4);
    io_write(`IMS_OFS_REMOTE, 8'h38);
    io_write(`IMS_OFS_PREAMP, 8'h20);
    io_write(`IMS_OFS_EQUATION, 8'ha0);
    io_write(`IMS_OFS_RATE_PLL, 8'h30);
    repeat (3) @(posedge core_clk);
    #5;
    check_val("diff_enable", 16'h0001, 16'(differential_pair_enable));
    check_val("preamp_gain8", 16'h0001, 16'(preamp_gain8));
    check_val("fields", 16'h0f5b, {4'h0, remote_sensor_enable, filter_length,
      energy_equation_select, 2'h2, rate_divide, pll_fast});
    io_write(`IMS_OFS_REMOTE, 8'h00);
    io_write(`IMS_OFS_PREAMP, 8'h00);
    repeat (3) @(posedge core_clk);
    #5;
    check_val("diff_enable", 16'h000f, 16'(differential_pair_enable));
    check_val("preamp_gain8", 16'h0000, 16'(preamp_gain8));
    run_frames(2'h0, 1'b0, 1'b1, 4'h2);
    run_frames(2'h1, 1'b1, 1'b0, 4'h3);
    io_write(`IMS_OFS_REMOTE, 8'h38);
    rmt_on = 1'b1;
    run_frames(2'h0, 1'b0, 1'b1, 4'hc);
    repeat (4) @(posedge core_clk);
    test_done();
  end
endmodule

`default_nettype wire
